// ==== nv_commit_pkg.sv ====
/*
 * Constants for the commit page select and crystal load-cap readback block.
 * Assumes a byte-wide register port driven by an I2C slave front end.
 */
// Functional notes
// - Commit page select is a 4-bit field, reset zero, naming the commit target page.
// - Six stored pages; two input pins pick the power-up default page.
// - 10-bit load-cap value readable only: bits 9:8 and 7:0 in two bytes.
// - Image holds six pages, common bytes placed first, then per-page bytes.
package nv_commit_pkg;
	localparam logic [7:0] COMMIT_PAGE_SELECT_OFS        = 8'h91;
	localparam logic [7:0] CRYSTAL_CAP_READBACK_HIGH_OFS = 8'hc7;
	localparam logic [7:0] CRYSTAL_CAP_READBACK_LOW_OFS  = 8'hc8;
	localparam logic [3:0] COMMIT_PAGE_RESET             = 4'h0;
	localparam logic [3:0] COMMIT_PAGE_LAST              = 4'h5;
	localparam int         PAGE_COUNT                    = 6;
	localparam int         COMMON_BYTES                  = 39;
	localparam int         PAGE_BYTES                    = 51;
	localparam int         IMAGE_ADDR_W                  = 9;
	localparam int         CAP_W                         = 10;
	localparam logic [9:0] CAP_RESET                     = 10'h000;
endpackage : nv_commit_pkg

// ==== page_map_if.sv ====
/*
 * Carrier between the register top and the page address mapper.
 * Assumes one clock domain.
 */
interface page_map_if;
	import nv_commit_pkg::*;
	logic [3:0]              page;
	logic [5:0]              offset;
	logic [IMAGE_ADDR_W-1:0] addr;
	logic                    valid;
	modport ctrl (output page, output offset, input addr, input valid);
	modport map  (input page, input offset, output addr, output valid);
endinterface : page_map_if

// ==== page_addr_map.sv ====
/*
 * Maps page and page-relative byte offset onto the image address.
 * Assumes offset below the per-page byte count.
 */
module page_addr_map
	import nv_commit_pkg::*;
(
	page_map_if.map pm // Page and offset in, address out
);
	localparam logic [IMAGE_ADDR_W-1:0] BASE = IMAGE_ADDR_W'(COMMON_BYTES);
	localparam logic [IMAGE_ADDR_W-1:0] STEP = IMAGE_ADDR_W'(PAGE_BYTES);

	// Common bytes come first, pages follow back to back
	assign pm.valid = (pm.page <= COMMIT_PAGE_LAST);
	assign pm.addr  = BASE + IMAGE_ADDR_W'(pm.page) * STEP
		+ IMAGE_ADDR_W'(pm.offset);
endmodule : page_addr_map

// ==== nv_commit_regs.sv ====
/*
 * Commit page select register, power-up page pick and load-cap readback.
 * Assumes a byte register port already decoded from I2C, one-cycle strobes.
 */
module nv_commit_regs
	import nv_commit_pkg::*;
(
	input  wire logic                    ref_clk,      // 50 MHz clock
	input  wire logic                    rst,          // Async reset, high
	input  wire logic [7:0]              reg_addr,     // Register address
	input  wire logic [7:0]              reg_wdata,    // Write data
	input  wire logic                    reg_wr,       // Write strobe
	input  wire logic                    reg_rd,       // Read strobe
	output logic      [7:0]              reg_rdata,    // Read data
	input  wire logic [1:0]              page_pins,    // Power-up page pins
	input  wire logic                    pins_latch,   // Latch pins, pulse
	input  wire logic [CAP_W-1:0]        cap_setting,  // Live load-cap value
	input  wire logic [5:0]              page_offset,  // Byte within page
	output logic      [IMAGE_ADDR_W-1:0] commit_addr,  // Commit address
	output logic                         commit_valid, // Page legal
	output logic      [2:0]              default_page  // Power-up page
);
	// ****************************************
	// Registers
	// ****************************************
	logic [3:0]       commit_page_field;
	logic [CAP_W-1:0] crystal_load_cap_value;
	page_map_if       pm ();

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			commit_page_field <= COMMIT_PAGE_RESET;
		end else if (reg_wr && reg_addr == COMMIT_PAGE_SELECT_OFS) begin
			commit_page_field <= reg_wdata[3:0];
		end
	end

	// Register resamples cap_setting every clock; the two readback bytes are not held coherent between reads
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			crystal_load_cap_value <= CAP_RESET;
		end else begin
			crystal_load_cap_value <= cap_setting;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			default_page <= 3'h0;
		end else if (pins_latch) begin
			default_page <= {1'b0, page_pins};
		end
	end

	// ****************************************
	// Read path
	// ****************************************
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			if (reg_addr == COMMIT_PAGE_SELECT_OFS) begin
				reg_rdata <= {4'h0, commit_page_field};
			end else if (reg_addr == CRYSTAL_CAP_READBACK_HIGH_OFS) begin
				reg_rdata <= {6'h00, crystal_load_cap_value[9:8]};
			end else if (reg_addr == CRYSTAL_CAP_READBACK_LOW_OFS) begin
				reg_rdata <= crystal_load_cap_value[7:0];
			end else begin
				reg_rdata <= 8'h00;
			end
		end
	end

	// ****************************************
	// Commit target
	// ****************************************
	assign pm.page   = commit_page_field;
	assign pm.offset = page_offset;

	page_addr_map u_map (
		.pm (pm)
	);

	// Illegal page codes are flagged, never mapped past the image
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			commit_addr  <= '0;
			commit_valid <= 1'b0;
		end else begin
			commit_addr  <= pm.valid ? pm.addr : '0;
			commit_valid <= pm.valid;
		end
	end

	// ****************************************
	// Checks: register port
	// ****************************************
	AST_PAGE_WRITE: assert property (
		@(posedge ref_clk) disable iff (rst)
		reg_wr && reg_addr == COMMIT_PAGE_SELECT_OFS
		|=> commit_page_field == $past(reg_wdata[3:0]))
		else $error("commit page not stored");

	AST_PAGE_HOLD: assert property (
		@(posedge ref_clk) disable iff (rst)
		!reg_wr
		|=> $stable(commit_page_field))
		else $error("page changed without write");

	// A write to any other offset must leave the page alone
	AST_PAGE_ONLY_OWN: assert property (
		@(posedge ref_clk) disable iff (rst)
		reg_wr && reg_addr != COMMIT_PAGE_SELECT_OFS
		|=> $stable(commit_page_field))
		else $error("page changed by foreign write");

	AST_PAGE_READ: assert property (
		@(posedge ref_clk) disable iff (rst)
		reg_rd && reg_addr == COMMIT_PAGE_SELECT_OFS
		|=> reg_rdata == {4'h0, $past(commit_page_field)})
		else $error("page readback wrong");

	AST_CAP_HIGH: assert property (
		@(posedge ref_clk) disable iff (rst)
		reg_rd && reg_addr == CRYSTAL_CAP_READBACK_HIGH_OFS
		|=> reg_rdata == {6'h00, $past(crystal_load_cap_value[9:8])})
		else $error("cap high byte wrong");

	AST_CAP_LOW: assert property (
		@(posedge ref_clk) disable iff (rst)
		reg_rd && reg_addr == CRYSTAL_CAP_READBACK_LOW_OFS
		|=> reg_rdata == $past(crystal_load_cap_value[7:0]))
		else $error("cap low byte wrong");

	AST_CAP_RO: assert property (
		@(posedge ref_clk) disable iff (rst)
		reg_wr
		|=> crystal_load_cap_value == $past(cap_setting))
		else $error("cap value writable");

	AST_CAP_SNAPSHOT: assert property (
		@(posedge ref_clk) disable iff (rst)
		$changed(cap_setting)
		|=> crystal_load_cap_value == $past(cap_setting))
		else $error("cap snapshot stale");

	AST_UNMAPPED_READ: assert property (
		@(posedge ref_clk) disable iff (rst)
		reg_rd && reg_addr != COMMIT_PAGE_SELECT_OFS
		&& reg_addr != CRYSTAL_CAP_READBACK_HIGH_OFS
		&& reg_addr != CRYSTAL_CAP_READBACK_LOW_OFS
		|=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");

	// Read data must stand until the next read strobe
	AST_RDATA_HOLD: assert property (
		@(posedge ref_clk) disable iff (rst)
		!reg_rd
		|=> $stable(reg_rdata))
		else $error("read data changed without read");

	// ****************************************
	// Checks: commit target
	// ****************************************
	AST_PAGE_LEGAL: assert property (
		@(posedge ref_clk) disable iff (rst)
		commit_page_field > COMMIT_PAGE_LAST
		|=> !commit_valid)
		else $error("illegal page accepted");

	AST_PAGE_ACCEPT: assert property (
		@(posedge ref_clk) disable iff (rst)
		commit_page_field <= COMMIT_PAGE_LAST
		|=> commit_valid)
		else $error("legal page refused");

	AST_ADDR_ILLEGAL: assert property (
		@(posedge ref_clk) disable iff (rst)
		!commit_valid
		|-> commit_addr == '0)
		else $error("illegal page mapped");

	AST_ADDR_LAYOUT: assert property (
		@(posedge ref_clk) disable iff (rst)
		commit_valid
		|-> commit_addr >= IMAGE_ADDR_W'(COMMON_BYTES))
		else $error("page overlaps common bytes");

	// Address lags the page and offset by one register stage
	AST_ADDR_EXACT: assert property (
		@(posedge ref_clk) disable iff (rst)
		commit_valid
		|-> commit_addr == IMAGE_ADDR_W'(COMMON_BYTES)
			+ IMAGE_ADDR_W'($past(commit_page_field))
			* IMAGE_ADDR_W'(PAGE_BYTES)
			+ IMAGE_ADDR_W'($past(page_offset)))
		else $error("commit address off layout");

	AST_ADDR_BOUND: assert property (
		@(posedge ref_clk) disable iff (rst)
		commit_valid && $past(page_offset) < PAGE_BYTES
		|-> commit_addr < IMAGE_ADDR_W'(COMMON_BYTES + PAGE_COUNT * PAGE_BYTES))
		else $error("commit address past image");

	// ****************************************
	// Checks: power-up page
	// ****************************************
	AST_DEFAULT_PAGE: assert property (
		@(posedge ref_clk) disable iff (rst)
		pins_latch
		|=> default_page == {1'b0, $past(page_pins)})
		else $error("default page not latched");

	// Pins may move freely once latched
	AST_DEFAULT_HOLD: assert property (
		@(posedge ref_clk) disable iff (rst)
		!pins_latch
		|=> $stable(default_page))
		else $error("default page moved without latch");

	// ****************************************
	// Coverage
	// ****************************************
	COV_PAGE5: cover property (@(posedge ref_clk) disable iff (rst)
		reg_wr && reg_addr == COMMIT_PAGE_SELECT_OFS
		&& reg_wdata[3:0] == COMMIT_PAGE_LAST);

	COV_CAP_READ: cover property (@(posedge ref_clk) disable iff (rst)
		reg_rd && reg_addr == CRYSTAL_CAP_READBACK_HIGH_OFS
		##[1:3] reg_rd && reg_addr == CRYSTAL_CAP_READBACK_LOW_OFS);

	COV_BAD_PAGE: cover property (@(posedge ref_clk) disable iff (rst)
		commit_page_field > COMMIT_PAGE_LAST);

	COV_DEFAULT_LATCH: cover property (@(posedge ref_clk) disable iff (rst)
		pins_latch && page_pins == 2'h3);

	COV_COMMIT_LAST: cover property (@(posedge ref_clk) disable iff (rst)
		commit_valid && commit_addr
		== IMAGE_ADDR_W'(COMMON_BYTES + PAGE_COUNT * PAGE_BYTES - 1));
endmodule : nv_commit_regs

// ==== host_model.sv ====
/* Register host model: byte writes and reads, one strobe each.
 * Assumes the block takes strobes on the rising clock edge. */
module host_model (
	input  wire logic       ref_clk,   // Block clock
	output logic      [7:0] reg_addr,  // Address
	output logic      [7:0] reg_wdata, // Write data
	output logic            reg_wr,    // Write strobe
	output logic            reg_rd     // Read strobe
);
	timeunit 1ns;
	timeprecision 1ps;
	// Host never writes image bytes nor starts a program cycle, so
	// reserved image bits, unlock key and bus quiet time stay unused
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	// Released lines show the inverse, never a stale value
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge ref_clk);
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask : wr
	task rd(input logic [7:0] a);
		@(negedge ref_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge ref_clk);
		reg_rd = 1'b0;
		reg_addr = ~a;
		@(negedge ref_clk);
	endtask : rd
endmodule : host_model

// ==== tb_top.sv ====
/* Self-checking bench for the commit page and load-cap block.
 * Assumes host_model drives the register port. */
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic       ref_clk = 1'b0, rst = 1'b1, pins_latch = 1'b0;
	logic [1:0] page_pins = 2'h0;
	logic [9:0] cap_setting = 10'h000;
	logic [5:0] page_offset = 6'h32;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic       reg_wr, reg_rd, commit_valid;
	logic [8:0] commit_addr;
	logic [2:0] default_page;
	int         num_errors = 0, checked = 0;
	always #10 ref_clk = ~ref_clk;
	host_model host_model_inst (.ref_clk, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd);
	nv_commit_regs nv_commit_regs_inst (.ref_clk, .rst, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .page_pins, .pins_latch,
		.cap_setting, .page_offset, .commit_addr, .commit_valid,
		.default_page);
	// ****************
	// Checking helpers
	// ****************
	task chk(input string n, input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s exp %h got %h", n, exp, got);
		end
	endtask : chk
	task rd_chk(input logic [7:0] a, input logic [7:0] exp);
		host_model_inst.rd(a);
		chk("reg_rdata", {8'h00, reg_rdata}, {8'h00, exp});
	endtask : rd_chk
	task stop_test;
		if (num_errors == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : stop_test
	// *********
	// Scenarios
	// *********
	task t_reset;
		rd_chk(8'h91, 8'h00);
		rd_chk(8'hc7, 8'h00);
		rd_chk(8'hc8, 8'h00);
		chk("commit_addr", 16'(commit_addr), 16'(39 + 50));
		chk("commit_valid", {15'h0, commit_valid}, 16'h0001);
		chk("default_page", {13'h0, default_page}, 16'h0000);
	endtask : t_reset
	// Offset 50 is the last page byte, the boundary case
	task t_pages;
		for (int p = 0; p < 6; p++) begin
			host_model_inst.wr(8'h91, {4'hf, 4'(p)});
			repeat (2) @(negedge ref_clk);
			chk("commit_addr", 16'(commit_addr), 16'(39 + p * 51 + 50));
			chk("commit_valid", {15'h0, commit_valid}, 16'h0001);
			rd_chk(8'h91, {4'h0, 4'(p)});
		end
	endtask : t_pages
	task t_cap;
		cap_setting = 10'h2a5;
		host_model_inst.wr(8'hc7, 8'hff);
		host_model_inst.wr(8'hc8, 8'h00);
		rd_chk(8'hc7, 8'h02);
		rd_chk(8'hc8, 8'ha5);
		rd_chk(8'h00, 8'h00);
	endtask : t_cap
	task t_pins;
		page_pins = 2'h3;
		@(negedge ref_clk);
		pins_latch = 1'b1;
		@(negedge ref_clk);
		pins_latch = 1'b0;
		page_pins = 2'h0;
		@(negedge ref_clk);
		chk("default_page", {13'h0, default_page}, 16'h0003);
	endtask : t_pins
	initial begin
		repeat (5) @(negedge ref_clk);
		rst = 1'b0;
		t_reset();
		t_pages();
		t_cap();
		t_pins();
		stop_test();
	end
	// Hang guard
	initial begin
		#100000;
		num_errors++;
		stop_test();
	end
endmodule : tb_top
